// ---- verilog/tif_pkg.sv ----
// shared constants and carriers for the tag id filter
package tif_pkg;
    localparam int TAG_ID_W = 64;
    localparam int ADDR_W = 8;
    localparam int NANT = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_RID = 8'h10;
    localparam logic [ADDR_W-1:0] REG_LAST = 8'h14;

    // status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_ERR = 1;
    localparam int ST_RPT = 2;
    localparam int ST_DROP = 3;
    localparam int ST_EXP = 4;
    localparam int ST_W = 5;

    // last response codes
    localparam logic [1:0] RESP_NONE = 2'h0;
    localparam logic [1:0] RESP_DONE = 2'h1;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // command codes, decimal value held in hex
    localparam logic [15:0] CMD_RESET = 16'h003F;
    localparam logic [15:0] CMD_TX_ALL = 16'h0028;
    localparam logic [15:0] CMD_TIME_OFF = 16'h012C;
    localparam logic [15:0] CMD_TIME_ON = 16'h012E;
    localparam logic [15:0] CMD_AUX_OFF = 16'h0136;
    localparam logic [15:0] CMD_AUX_ON = 16'h0137;
    localparam logic [15:0] CMD_UNIQ_RST = 16'h01B8;
    localparam logic [15:0] CMD_TO_BASE = 16'h01B8;
    localparam logic [15:0] CMD_SEP_BASE = 16'h1004;
    localparam logic [15:0] CMD_VAL_BASE = 16'h1068;

    // timeout selections: 0 long, 1 short, 2 mid
    localparam logic [1:0] TO_SEL_LONG = 2'h0;
    localparam int CLK_HZ = 10_000_000;
    localparam int TO_LONG_S = 120;
    localparam int TO_SHORT_S = 15;
    localparam int TO_MID_S = 30;
    localparam logic [31:0] TO_LONG_CYC = 32'(TO_LONG_S * CLK_HZ);
    localparam logic [31:0] TO_SHORT_CYC = 32'(TO_SHORT_S * CLK_HZ);
    localparam logic [31:0] TO_MID_CYC = 32'(TO_MID_S * CLK_HZ);

    // reset values
    localparam logic RST_TIME_EN = 1'b1;
    localparam logic RST_AUX_EN = 1'b0;
    localparam logic [1:0] RST_SEP = 2'h0;
    localparam logic [1:0] RST_NEED = 2'h0;
    localparam logic [7:0] RST_RID = 8'h01;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] hundredth;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] year;
    } tif_stamp_t;

    typedef struct packed {
        logic [TAG_ID_W-1:0] id;
        logic [1:0] antenna;
        logic [7:0] strength;
    } tif_tag_t;

    typedef struct packed {
        logic [7:0] reader_id;
        logic [1:0] antenna;
        logic [7:0] prev_reads;
        logic [1:0] sense;
        logic [7:0] strength;
    } tif_aux_t;

    typedef struct packed {
        logic [TAG_ID_W-1:0] id;
        logic time_en;
        tif_stamp_t stamp;
        logic aux_en;
        tif_aux_t aux;
    } tif_report_t;
endpackage

// ---- verilog/tif_filter.sv ----
// tag id validation and uniqueness filter with append options, axi4-lite slave
// Notes on behaviour
// - time/date append off by 300, on by 302, on after reset.
// - time/date option change answers error while a report is pending.
// - time/date suffix follows message as ampersand, time, space, date.
// - aux append off by 310 (default), on by 311; never on errors.
// - aux suffix: reader id, antenna, previous read count, sense pair, strength.
// - transmit-all bypasses uniqueness until a separation command arrives.
// - separation of 1 to 4 ids by 4100..4103, one by default.
// - history holds four newest acquired ids, newest first.
// - report only if different from the S newest history entries.
// - every validated id enters history, reported or not.
// - an id is accepted again after timeout or after differing ids.
// - validate after 1 to 4 consecutive same reads per antenna, 4200..4203.
// - validation runs before uniqueness; failures go nowhere.
// - reset command 63 discards the pending report.
// - timeout 2 min default, 15 s, 30 s by 441, 442, 443.
// - timeout restarts on every acquired id, so a parked tag stays quiet.
// - timeout expiry or selection command empties the history.
`timescale 1ns/1ps
module tif_filter #(
    parameter logic [31:0] TO_LONG = tif_pkg::TO_LONG_CYC,
    parameter logic [31:0] TO_SHORT = tif_pkg::TO_SHORT_CYC,
    parameter logic [31:0] TO_MID = tif_pkg::TO_MID_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [tif_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tif_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tag_valid,
    input wire tif_pkg::tif_tag_t tag_in,
    input wire logic sense_line_a,
    input wire logic sense_line_b,
    input wire tif_pkg::tif_stamp_t stamp_in,
    output logic rpt_valid,
    input wire logic rpt_ready,
    output tif_pkg::tif_report_t rpt,
    output logic irq
);
    import tif_pkg::*;

    // bus group
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d, araddr_n;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [ST_W-1:0] st_q, st_d, mask_q, mask_d;
    logic [7:0] rid_q, rid_d;
    logic [1:0] last_q, last_d;
    logic [15:0] code_q, code_d;
    logic wr_go, cmd_go;
    // filter group
    logic time_en_q, time_en_d, aux_en_q, aux_en_d, tx_all_q, tx_all_d;
    logic [1:0] sep_q, sep_d, need_q, need_d, to_sel_q, to_sel_d;
    logic [TAG_ID_W-1:0] hist_q [4];
    logic [TAG_ID_W-1:0] hist_d [4];
    logic [3:0] hv_q, hv_d, hmatch;
    logic [TAG_ID_W-1:0] ant_id_q [NANT];
    logic [TAG_ID_W-1:0] ant_id_d [NANT];
    logic [7:0] run_q [NANT];
    logic [7:0] run_d [NANT];
    logic [7:0] prev_q [NANT];
    logic [7:0] prev_d [NANT];
    logic [NANT-1:0] ahv_q, ahv_d;
    logic [31:0] to_cnt_q, to_cnt_d, to_lim;
    tif_report_t out_q, out_d;
    logic out_v_q, out_v_d;
    logic same, v_ok, dup, rpt_push, expire;
    logic [7:0] run_nx, prev_now;
    logic ev_done, ev_err, ev_drop;

    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    assign cmd_go = wr_go && awaddr_q == REG_CMD && wstrb_q[1:0] == 2'h3;
    // kept out of the bus process so the filter logic reads it without a process loop
    assign code_d = cmd_go ? wdata_q[15:0] : code_q;
    assign s_axi_awready = ce && !aw_have_q;
    assign s_axi_wready = ce && !w_have_q;
    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign araddr_n = s_axi_araddr;
    assign irq = |(st_q & mask_q);
    assign rpt_valid = out_v_q;
    assign rpt = out_q;

    always_comb begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        mask_d = mask_q;
        rid_d = rid_q;
        last_d = ev_done ? RESP_DONE : (ev_err ? RESP_ERR : last_q);
        // set beats clear in the same cycle
        st_d = st_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            unique case (awaddr_q)
                REG_CMD, REG_CFG, REG_LAST: ;
                REG_STAT: if (wstrb_q[0]) st_d = st_q & ~wdata_q[ST_W-1:0];
                REG_MASK: if (wstrb_q[0]) mask_d = wdata_q[ST_W-1:0];
                REG_RID: if (wstrb_q[0]) rid_d = wdata_q[7:0];
                default: bresp_d = 2'h2;
            endcase
        end
        st_d = st_d | {expire, ev_drop, rpt_push, ev_err, ev_done};
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            rdata_d = 32'h0000_0000;
            unique case (araddr_n)
                REG_CMD: rdata_d[15:0] = code_q;
                REG_CFG: rdata_d[9:0] = {out_v_q, tx_all_q, aux_en_q, time_en_q,
                                         to_sel_q, need_q, sep_q};
                REG_STAT: rdata_d[ST_W-1:0] = st_q;
                REG_MASK: rdata_d[ST_W-1:0] = mask_q;
                REG_RID: rdata_d[7:0] = rid_q;
                REG_LAST: rdata_d[1:0] = last_q;
                default: rresp_d = 2'h2;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            st_q <= '0;
            mask_q <= '0;
            rid_q <= RST_RID;
            last_q <= RESP_NONE;
            code_q <= 16'h0000;
        end else if (ce) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            mask_q <= mask_d;
            rid_q <= rid_d;
            last_q <= last_d;
            code_q <= code_d;
        end
    end

    // full-width compare, empty entries never match
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_cmp
        assign hmatch[gi] = hv_q[gi] && hist_q[gi] == tag_in.id && gi <= sep_q;
    end

    always_comb begin
        same = ahv_q[tag_in.antenna] && ant_id_q[tag_in.antenna] == tag_in.id;
        run_nx = same ? (run_q[tag_in.antenna] == 8'hFF ? 8'hFF
                         : run_q[tag_in.antenna] + 8'h01) : 8'h01;
        prev_now = same ? prev_q[tag_in.antenna]
                        : (ahv_q[tag_in.antenna] ? run_q[tag_in.antenna] : 8'h00);
        // once the run is long enough every further read passes on, so a parked tag
        // keeps feeding the uniqueness stage and its timeout
        v_ok = tag_valid && run_nx > {6'h00, need_q};
        dup = |hmatch && !tx_all_q;
        unique case (to_sel_q)
            2'h1: to_lim = TO_SHORT;
            2'h2: to_lim = TO_MID;
            default: to_lim = TO_LONG;
        endcase
        expire = hv_q != 4'h0 && to_cnt_q >= to_lim - 32'h1;
        time_en_d = time_en_q;
        aux_en_d = aux_en_q;
        tx_all_d = tx_all_q;
        sep_d = sep_q;
        need_d = need_q;
        to_sel_d = to_sel_q;
        hist_d = hist_q;
        hv_d = hv_q;
        ant_id_d = ant_id_q;
        run_d = run_q;
        prev_d = prev_q;
        ahv_d = ahv_q;
        out_d = out_q;
        out_v_d = out_v_q && !rpt_ready;
        to_cnt_d = hv_q != 4'h0 ? to_cnt_q + 32'h1 : 32'h0;
        ev_done = 1'b0;
        ev_err = 1'b0;
        ev_drop = 1'b0;
        rpt_push = 1'b0;
        if (expire) begin
            hv_d = 4'h0;
            to_cnt_d = 32'h0;
        end
        if (tag_valid) begin
            ant_id_d[tag_in.antenna] = tag_in.id;
            ahv_d[tag_in.antenna] = 1'b1;
            run_d[tag_in.antenna] = run_nx;
            prev_d[tag_in.antenna] = prev_now;
        end
        if (v_ok) begin
            // every acquired id restarts the clock
            to_cnt_d = 32'h0;
            hist_d[3] = hist_q[2];
            hist_d[2] = hist_q[1];
            hist_d[1] = hist_q[0];
            hist_d[0] = tag_in.id;
            hv_d = {hv_q[2:0], 1'b1};
            if (expire) hv_d = 4'h1;
            if (!dup || expire) begin
                if (!out_v_d) begin
                    rpt_push = 1'b1;
                    out_v_d = 1'b1;
                    out_d.id = tag_in.id;
                    out_d.time_en = time_en_q;
                    out_d.stamp = stamp_in;
                    out_d.aux_en = aux_en_q;
                    out_d.aux = '{rid_q, tag_in.antenna, prev_now,
                                  {sense_line_b, sense_line_a}, tag_in.strength};
                end else begin
                    ev_drop = 1'b1;
                end
            end
        end
        if (cmd_go) begin
            ev_done = 1'b1;
            if (code_d == CMD_RESET) begin
                out_v_d = 1'b0;
                rpt_push = 1'b0;
                ev_drop = 1'b0;
            end else if (code_d == CMD_TIME_OFF || code_d == CMD_TIME_ON) begin
                if (out_v_q) begin
                    ev_done = 1'b0;
                    ev_err = 1'b1;
                end else begin
                    time_en_d = code_d == CMD_TIME_ON;
                end
            end else if (code_d == CMD_AUX_OFF || code_d == CMD_AUX_ON) begin
                aux_en_d = code_d == CMD_AUX_ON;
            end else if (code_d == CMD_TX_ALL) begin
                tx_all_d = 1'b1;
            end else if (code_d >= CMD_SEP_BASE && code_d <= CMD_SEP_BASE + 16'h3) begin
                sep_d = 2'(code_d - CMD_SEP_BASE);
                tx_all_d = 1'b0;
            end else if (code_d >= CMD_VAL_BASE && code_d <= CMD_VAL_BASE + 16'h3) begin
                need_d = 2'(code_d - CMD_VAL_BASE);
            end else if (code_d >= CMD_UNIQ_RST && code_d <= CMD_TO_BASE + 16'h3) begin
                if (code_d != CMD_UNIQ_RST) to_sel_d = 2'(code_d - CMD_TO_BASE - 16'h1);
                hv_d = 4'h0;
                to_cnt_d = 32'h0;
            end else begin
                ev_done = 1'b0;
                ev_err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            time_en_q <= RST_TIME_EN;
            aux_en_q <= RST_AUX_EN;
            tx_all_q <= 1'b0;
            sep_q <= RST_SEP;
            need_q <= RST_NEED;
            to_sel_q <= TO_SEL_LONG;
            hist_q <= '{default: '0};
            hv_q <= 4'h0;
            ant_id_q <= '{default: '0};
            run_q <= '{default: 8'h00};
            prev_q <= '{default: 8'h00};
            ahv_q <= '0;
            to_cnt_q <= 32'h0;
            out_q <= '0;
            out_v_q <= 1'b0;
        end else if (ce) begin
            time_en_q <= time_en_d;
            aux_en_q <= aux_en_d;
            tx_all_q <= tx_all_d;
            sep_q <= sep_d;
            need_q <= need_d;
            to_sel_q <= to_sel_d;
            hist_q <= hist_d;
            hv_q <= hv_d;
            ant_id_q <= ant_id_d;
            run_q <= run_d;
            prev_q <= prev_d;
            ahv_q <= ahv_d;
            to_cnt_q <= to_cnt_d;
            out_q <= out_d;
            out_v_q <= out_v_d;
        end
    end

    a_dup_suppress: assert property (@(posedge clk) disable iff (srst)
        v_ok && !tx_all_q && !expire && hv_q[0] && hist_q[0] == tag_in.id |-> !rpt_push)
        else $error("duplicate id reported");
    a_hist_push: assert property (@(posedge clk) disable iff (srst)
        ce && v_ok |=> hv_q[0] && hist_q[0] == $past(tag_in.id))
        else $error("acquired id missing from history");
    a_tx_all_pass: assert property (@(posedge clk) disable iff (srst)
        ce && v_ok && tx_all_q && !out_v_q && !cmd_go |=> rpt_valid && rpt.id == $past(tag_in.id))
        else $error("transmit-all dropped an id");
    a_reset_clear: assert property (@(posedge clk) disable iff (srst)
        ce && cmd_go && code_d == CMD_RESET |=> !rpt_valid)
        else $error("reset left a report pending");
    a_time_lock: assert property (@(posedge clk) disable iff (srst)
        ce && cmd_go && code_d == CMD_TIME_OFF && out_v_q
        |=> time_en_q == $past(time_en_q) && st_q[ST_ERR] && last_q == RESP_ERR)
        else $error("time option changed with pending data");
    a_expire_clear: assert property (@(posedge clk) disable iff (srst)
        ce && expire |=> hv_q[3:1] == 3'h0 && to_cnt_q == 32'h0)
        else $error("history survived timeout");
    a_valid_run: assert property (@(posedge clk) disable iff (srst)
        v_ok && need_q != 2'h0 |-> same && run_q[tag_in.antenna] >= {6'h00, need_q})
        else $error("id validated without consecutive reads");
    a_sep_done: assert property (@(posedge clk) disable iff (srst)
        ce && cmd_go && code_d == CMD_SEP_BASE + 16'h1
        |=> sep_q == 2'h1 && !tx_all_q && st_q[ST_DONE] ##1 last_q == RESP_DONE)
        else $error("separation command not applied");
endmodule

// ---- verif/tif_host.sv ----
// report consumer that stands in for the host
`timescale 1ns/1ps
module tif_host (
    input wire logic clk,
    input wire logic srst,
    input wire logic stall,
    input wire logic rpt_valid,
    input wire tif_pkg::tif_report_t rpt,
    output logic rpt_ready,
    output logic [15:0] cnt,
    output tif_pkg::tif_report_t last
);
    import tif_pkg::*;
    // stall makes a slow host, so a report is left pending in the block
    always_ff @(posedge clk) begin
        if (srst) begin
            rpt_ready <= 1'b0;
            cnt <= 16'h0000;
        end else begin
            rpt_ready <= !stall;
            if (rpt_valid && rpt_ready) begin
                cnt <= cnt + 16'h0001;
                last <= rpt;
            end
        end
    end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the tag id filter
`timescale 1ns/1ps
module tb;
    import tif_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic tag_valid = 1'b0;
    logic sense_a = 1'b0;
    logic sense_b = 1'b0;
    logic stall = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, rpt_valid, rpt_ready;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] cnt;
    tif_tag_t tag_in = '0;
    tif_stamp_t stamp = 56'h12_34_56_78_09_1A_24;
    tif_report_t rpt, last;
    int bad_count = 0;
    int checks = 0;
    int exp_cnt = 0;

    always #50 clk = ~clk;

    // short timeouts: 200, 50 and 100 cycles stand in for 2 min, 15 s, 30 s
    tif_filter #(.TO_LONG(32'h0000_00C8), .TO_SHORT(32'h0000_0032),
        .TO_MID(32'h0000_0064)) tif_filter_inst (
        .clk(clk), .srst(srst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tag_valid(tag_valid),
        .tag_in(tag_in), .sense_line_a(sense_a), .sense_line_b(sense_b),
        .stamp_in(stamp), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
        .rpt(rpt), .irq(irq)
    );
    tif_host tif_host_inst (
        .clk(clk), .srst(srst), .stall(stall), .rpt_valid(rpt_valid), .rpt(rpt),
        .rpt_ready(rpt_ready), .cnt(cnt), .last(last)
    );

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // handshakes judged at the falling edge, released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb_;
        int n;
        n = 0;
        tb_ = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb_ && n < 50) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb_ = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        chk("write_answer", 1, tb_);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int n;
        n = 0;
        tr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr && n < 50) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        chk("read_answer", 1, tr);
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(name, e, d & m);
    endtask

    task automatic cmd(input logic [15:0] code, input logic [1:0] e);
        logic [1:0] r;
        wr(REG_CMD, {16'h0000, code}, r);
        rchk("last_resp", REG_LAST, 32'h3, {30'h0, e});
    endtask

    task automatic tag(input logic [63:0] v, input logic [1:0] ant, input logic rep);
        @(posedge clk);
        tag_valid <= 1'b1;
        tag_in <= '{id: v, antenna: ant, strength: 8'h5A};
        @(posedge clk);
        tag_valid <= 1'b0;
        exp_cnt += rep;
        repeat (4) @(posedge clk);
        chk("reports", exp_cnt, cnt);
        if (rep) chk("rpt_id", v, last.id);
    endtask

    // command codes are decimal numbers written here in hex
    task automatic t_codes();
        chk("idle_after_reset", 4'h0, {rpt_valid, irq, bvalid, rvalid});
        rchk("cfg", REG_CFG, 32'h3FF, 32'h040);
        rchk("reader_id", REG_RID, 32'hFF, 32'h01);
        for (int k = 0; k < 4; k++) begin
            cmd(16'h1004 + 16'(k), RESP_DONE);
            cmd(16'h1068 + 16'(k), RESP_DONE);
            rchk("cfg", REG_CFG, 32'h00F, 32'(k * 5));
        end
        for (int k = 2; k >= 0; k--) begin
            cmd(16'h01B9 + 16'(k), RESP_DONE);
            rchk("cfg", REG_CFG, 32'h030, 32'(k << 4));
        end
        cmd(16'h03E7, RESP_ERR);
        cmd(16'h1004, RESP_DONE);
        cmd(16'h1068, RESP_DONE);
        $display("test codes done");
    endtask

    task automatic t_uniq();
        cmd(16'h01B8, RESP_DONE);
        tag(64'h0A, 2'h0, 1'b1);
        tag(64'h0A, 2'h0, 1'b0);
        tag(64'h80000000_0000000A, 2'h0, 1'b1);
        tag(64'h0B, 2'h0, 1'b1);
        tag(64'h0A, 2'h0, 1'b1);
        cmd(16'h1005, RESP_DONE);
        cmd(16'h01B8, RESP_DONE);
        tag(64'h0A, 2'h0, 1'b1);
        tag(64'h0B, 2'h0, 1'b1);
        tag(64'h0A, 2'h0, 1'b0);
        tag(64'h0C, 2'h0, 1'b1);
        tag(64'h0A, 2'h0, 1'b0);
        cmd(16'h1007, RESP_DONE);
        cmd(16'h01B8, RESP_DONE);
        for (int k = 0; k < 4; k++) tag(64'h10 + 64'(k), 2'h0, 1'b1);
        tag(64'h10, 2'h0, 1'b0);
        tag(64'h14, 2'h0, 1'b1);
        tag(64'h11, 2'h0, 1'b1);
        cmd(16'h0028, RESP_DONE);
        tag(64'h11, 2'h0, 1'b1);
        tag(64'h11, 2'h0, 1'b1);
        cmd(16'h1004, RESP_DONE);
        tag(64'h11, 2'h0, 1'b0);
        cmd(16'h1069, RESP_DONE);
        tag(64'h15, 2'h1, 1'b0);
        tag(64'h16, 2'h1, 1'b0);
        tag(64'h16, 2'h1, 1'b1);
        tag(64'h16, 2'h1, 1'b0);
        cmd(16'h1068, RESP_DONE);
        $display("test uniqueness done");
    endtask

    task automatic t_timeout();
        tag(64'h20, 2'h0, 1'b1);
        cmd(16'h01B9, RESP_DONE);
        tag(64'h20, 2'h0, 1'b1);
        tag(64'h20, 2'h0, 1'b0);
        repeat (150) @(posedge clk);
        tag(64'h20, 2'h0, 1'b0);
        repeat (150) @(posedge clk);
        tag(64'h20, 2'h0, 1'b0);
        repeat (250) @(posedge clk);
        tag(64'h20, 2'h0, 1'b1);
        cmd(16'h01BA, RESP_DONE);
        tag(64'h20, 2'h0, 1'b1);
        repeat (30) @(posedge clk);
        tag(64'h20, 2'h0, 1'b0);
        repeat (60) @(posedge clk);
        tag(64'h20, 2'h0, 1'b1);
        cmd(16'h01B9, RESP_DONE);
        $display("test timeout done");
    endtask

    task automatic t_append();
        stall <= 1'b1;
        tag(64'h21, 2'h0, 1'b0);
        cmd(16'h012C, RESP_ERR);
        rchk("cfg", REG_CFG, 32'h240, 32'h240);
        stall <= 1'b0;
        exp_cnt++;
        tag(64'h22, 2'h0, 1'b1);
        cmd(16'h012C, RESP_DONE);
        tag(64'h23, 2'h0, 1'b1);
        chk("time_en", 0, last.time_en);
        cmd(16'h012E, RESP_DONE);
        tag(64'h24, 2'h0, 1'b1);
        chk("time_en", 1, last.time_en);
        chk("stamp", stamp, last.stamp);
        cmd(16'h0137, RESP_DONE);
        sense_b <= 1'b1;
        tag(64'h32, 2'h2, 1'b1);
        tag(64'h32, 2'h2, 1'b0);
        tag(64'h32, 2'h2, 1'b0);
        tag(64'h33, 2'h2, 1'b1);
        chk("aux_en", 1, last.aux_en);
        chk("aux", {8'h01, 2'h2, 8'h03, 2'h2, 8'h5A}, last.aux);
        cmd(16'h0136, RESP_DONE);
        sense_b <= 1'b0;
        tag(64'h34, 2'h0, 1'b1);
        chk("aux_en", 0, last.aux_en);
        $display("test append done");
    endtask

    task automatic t_misc();
        logic [31:0] d;
        logic [1:0] r;
        stall <= 1'b1;
        tag(64'h41, 2'h0, 1'b0);
        chk("rpt_valid", 1, rpt_valid);
        cmd(16'h003F, RESP_DONE);
        chk("rpt_valid", 0, rpt_valid);
        stall <= 1'b0;
        tag(64'h42, 2'h0, 1'b1);
        wr(REG_STAT, 32'h1F, r);
        wr(REG_MASK, 32'(1 << ST_RPT), r);
        tag(64'h43, 2'h0, 1'b1);
        chk("irq", 1, irq);
        wr(REG_MASK, 32'h0, r);
        chk("irq", 0, irq);
        wr(REG_MASK, 32'(1 << ST_RPT), r);
        chk("irq", 1, irq);
        wr(REG_STAT, 32'(1 << ST_RPT), r);
        chk("irq", 0, irq);
        wr(8'h40, 32'h0, r);
        chk("bresp", 2'h2, r);
        rd(8'h44, d, r);
        chk("rresp", 2'h2, r);
        $display("test misc done");
    endtask

    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_codes();
        t_uniq();
        t_timeout();
        t_append();
        t_misc();
        end_sim();
    end

    // the run needs about twelve hundred cycles; this allows twenty thousand
    initial begin
        #2000000;
        bad_count++;
        end_sim();
    end
endmodule
